// ---- verification/rxcb_atm_reader.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxcb_atm_reader (
  input wire logic clk, // Bus clock
  input wire logic clav, // Cell available
  input wire logic [15:0] bus, // Resolved data lines
  input wire logic soc, // Start of cell
  input wire logic [6:0] nw, // Words per cell
  input wire logic slow, // Pause between words
  input wire logic hold, // Stall the reader
  output logic en_n // Read enable, active low
);
  logic [16:0] got[$];
  int left = 0;
  int gap = 0;
  logic pend = 1'h0;
  initial en_n = 1'h1;
  always @(posedge clk) begin
    if (pend) got.push_back({soc, bus});
    pend = !en_n && left > 0;
    if (pend) left--;
    gap = en_n ? gap + 1 : 0;
    // Idle gap lets clav settle after a cell before trusting it
    if (left == 0 && gap > 2 && clav && !hold) begin
      left = nw;
      en_n <= 1'h0;
    end else
      en_n <= left == 0 || (slow && !en_n);
  end
endmodule // rxcb_atm_reader
`default_nettype wire

// ---- verification/rxcb_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxcb_port_chk (
  input wire logic clk, // System clock
  input wire logic rstn, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic rx_bus_clock, // Link clock
  input wire logic rx_read_enable_n, // Read enable
  input wire rxcb_pkg::rxcb_word_t rx_cell_data_bus, // Cell data
  input wire logic [1:0] rx_data_oe_n, // Lane enables
  input wire logic rx_start_of_cell, // Start of cell
  input wire logic rx_odd_parity_out, // Parity
  input wire logic cell_available_out // Cell available
);
  AST_APB_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    psel && !penable |=> !pready ##1 pready) else $error("APB wait state wrong");
  AST_SOC_ONE: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    rx_start_of_cell |=> !rx_start_of_cell) else $error("Start of cell too long");
  AST_SOC_CLAV: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    rx_start_of_cell |-> $past(cell_available_out) && !$past(rx_read_enable_n)) else $error("Cell start without clav");
  AST_PAR: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    rx_data_oe_n != 2'h3 |-> ^{rx_cell_data_bus, rx_odd_parity_out}) else $error("Parity not odd");
  AST_HIZ: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    rx_read_enable_n |=> rx_data_oe_n == 2'h3) else $error("Bus driven while disabled");
  AST_LANE: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    !rx_data_oe_n[0] |-> !rx_data_oe_n[1]) else $error("Lower lane alone");
  AST_HOLD: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    rx_read_enable_n |=> $stable(rx_cell_data_bus)) else $error("Data moved without read");
  AST_CLAV_RST: assert property (@(posedge rx_bus_clock) disable iff (!rstn)
    $rose(rstn) |-> !cell_available_out [*4]) else $error("Clav high after reset");
endmodule // rxcb_port_chk
bind rxcb_port rxcb_port_chk i_rxcb_port_chk (.clk, .rstn, .psel, .penable, .pready, .rx_bus_clock,
  .rx_read_enable_n, .rx_cell_data_bus, .rx_data_oe_n, .rx_start_of_cell, .rx_odd_parity_out,
  .cell_available_out);
`default_nettype wire

// ---- verification/rxcb_port_tb_top.sv ----
`timescale 1ns/1ps
`include "rxcb_map.svh"
`default_nettype none
module rxcb_port_tb_top;
  import rxcb_pkg::*;
  localparam logic [15:0] CTRL_A = `RXCB_CTRL_IDX << 2;
  localparam logic [15:0] STAT_A = `RXCB_STAT_IDX << 2;
  logic clk = 1'h0, rx_bus_clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic in_valid = 1'h0, in_end = 1'h0, slow = 1'h0, hold = 1'h0;
  logic [15:0] paddr = 16'h0, bus;
  logic [6:0] nw = 7'h34;
  rxcb_apb_data_t pwdata = 32'h0, prdata;
  rxcb_octet_t in_octet = 8'h0;
  rxcb_word_t rx_cell_data_bus;
  logic [1:0] rx_data_oe_n;
  logic pready, pslverr, in_ready, rx_read_enable_n, rx_start_of_cell, rx_odd_parity_out, cell_available_out;
  int num_errors = 0, checks_done = 0;
  initial forever #12.5 clk = !clk;
  initial begin
    #1.7;
    forever #3 rx_bus_clock = !rx_bus_clock;
  end
  assign bus = {rx_data_oe_n[1] ? 8'hZZ : rx_cell_data_bus[15:8], rx_data_oe_n[0] ? 8'hZZ : rx_cell_data_bus[7:0]};
  rxcb_port i_rxcb_port (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_octet, .in_end, .in_ready, .rx_bus_clock, .rx_read_enable_n, .rx_cell_data_bus,
    .rx_data_oe_n, .rx_start_of_cell, .rx_odd_parity_out, .cell_available_out);
  rxcb_atm_reader i_rxcb_atm_reader (.clk(rx_bus_clock), .clav(cell_available_out), .bus,
    .soc(rx_start_of_cell), .nw, .slow, .hold, .en_n(rx_read_enable_n));
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge clk);
  endtask
  // Octets of cell c start at 10h + 70h*c so cells stay distinguishable
  task automatic push(input int n, nc);
    for (int c = 0; c < nc; c++)
      for (int i = 0; i < n; i++) begin
        in_valid <= 1'h1; in_octet <= 8'(8'h10 + 8'h70 * c + i); in_end <= i == n - 1;
        @(posedge clk);
        while (!in_ready) @(posedge clk);
      end
    in_valid <= 1'h0; in_end <= 1'h0;
  endtask
  task automatic drain(input int n, w, nc);
    int m;
    logic [7:0] o;
    m = n / w;
    for (int k = 0; k < 2000 && i_rxcb_atm_reader.got.size() < m * nc; k++) @(posedge clk);
    for (int i = 0; i < m * nc; i++) begin
      o = 8'(8'h10 + 8'h70 * (i / m) + w * (i % m));
      chk(32'(i_rxcb_atm_reader.got.pop_front()), {15'h0, i % m == 0, o, w == 2 ? 8'(o + 1) : 8'hZZ});
    end
    repeat (10) @(posedge clk);
    chk(32'(cell_available_out), 32'h0);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    chk(32'(cell_available_out), 32'h0);
    apb(1'h0, STAT_A, 32'h0, r, e);
    chk(r, 32'h00010000);
    apb(1'h0, CTRL_A, 32'h0, r, e);
    chk(r, 32'h83);
    chk(32'(e), 32'h0);
    apb(1'h1, CTRL_A, 32'hFF, r, e);
    apb(1'h0, CTRL_A, 32'h0, r, e);
    chk(r, 32'hFF);
    apb(1'h0, 16'h0FF0, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    $display("t_regs done");
  endtask
  // Inactive bus keeps the cell queued; enabling 8-bit mode then releases it
  task automatic t_off;
    logic [31:0] r;
    logic e;
    apb(1'h1, CTRL_A, 32'h80, r, e);
    nw <= 7'h34;
    push(52, 1);
    repeat (20) @(posedge clk);
    chk(32'(cell_available_out), 32'h0);
    apb(1'h0, STAT_A, 32'h0, r, e);
    chk(r, 32'h00000034);
    // 16-bit with 53 octets, and the unused size, both keep the bus idle
    apb(1'h1, CTRL_A, 32'h89, r, e);
    repeat (20) @(posedge clk);
    chk(32'(cell_available_out), 32'h0);
    apb(1'h1, CTRL_A, 32'h87, r, e);
    repeat (20) @(posedge clk);
    chk(32'(cell_available_out), 32'h0);
    apb(1'h1, CTRL_A, 32'h84, r, e);
    drain(52, 1, 1);
    apb(1'h0, STAT_A, 32'h0, r, e);
    chk(r, 32'h00010000);
    $display("t_off done");
  endtask
  task automatic t_cells(input logic [7:0] c, input int n, input logic s);
    logic [31:0] r;
    logic e;
    int w;
    w = c[3:2] == 2'h2 ? 2 : 1;
    hold <= 1'h1; slow <= s; nw <= 7'(n / w);
    apb(1'h1, CTRL_A, {24'h0, c}, r, e);
    repeat (4) @(posedge clk);
    push(n, 2);
    repeat (10) @(posedge clk);
    chk(32'(cell_available_out), 32'h1);
    hold <= 1'h0;
    drain(n, w, 2);
    $display("t_cells %h done", c);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    t_regs;
    t_off;
    t_cells(8'h84, 52, 1'h0);
    t_cells(8'h85, 53, 1'h1);
    t_cells(8'h88, 52, 1'h0);
    t_cells(8'h8A, 54, 1'h1);
    t_cells(8'h05, 53, 1'h0);
    t_cells(8'h0A, 54, 1'h1);
    end_sim;
  end
  initial begin
    #2000000;
    num_errors++;
    end_sim;
  end
endmodule // rxcb_port_tb_top
`default_nettype wire

// ---- verilog/rxcb_cell_queue.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxcb_cell_queue #(
  parameter int AW = 10
) (
  input wire logic wclk, // Write side clock
  input wire logic wrst_n, // Write side reset, active low
  input wire logic rclk, // Read side clock
  input wire logic rrst_n, // Read side reset, active low
  rxcb_q_if.queue q // Queue access
);
  import rxcb_pkg::*;
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] DEPTH_W = {1'b1, {AW{1'b0}}};

  rxcb_octet_t mem_reg [DEPTH];
  logic [AW:0] wptr_reg, wcommit_reg, wpub_reg, wcg_reg, rg_s1_reg, rg_s2_reg;
  logic [AW:0] rptr_reg, rpub_reg, rg_reg, wcg_s1_reg, wcg_s2_reg;
  logic [AW:0] rptr_wr, wcommit_rd;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  always_ff @(posedge wclk) begin
    if (q.push) begin
      mem_reg[wptr_reg[AW-1:0]] <= q.push_octet;
    end
  end

  // Commit jumps a whole cell; the published copy steps one octet a clock so one gray bit moves at a time
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wptr_reg <= '0;
      wcommit_reg <= '0;
      wpub_reg <= '0;
      wcg_reg <= '0;
    end else begin
      if (q.push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (q.commit) begin
        wcommit_reg <= wptr_reg + 1'b1;
      end
      if (wpub_reg != wcommit_reg) begin
        wpub_reg <= wpub_reg + 1'b1;
      end
      wcg_reg <= bin2gray(wpub_reg);
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      rg_s1_reg <= rg_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rptr_reg <= '0;
      rpub_reg <= '0;
      rg_reg <= '0;
    end else begin
      if (q.pop) begin
        rptr_reg <= rptr_reg + (q.pop_two ? (AW+1)'(2) : (AW+1)'(1));
      end
      // Two-octet pops would move two gray bits; the write side sees free space a little late instead
      if (rpub_reg != rptr_reg) begin
        rpub_reg <= rpub_reg + 1'b1;
      end
      rg_reg <= bin2gray(rpub_reg);
    end
  end

  // Memory words are stable before their committed pointer reaches this side
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      wcg_s1_reg <= '0;
      wcg_s2_reg <= '0;
    end else begin
      wcg_s1_reg <= wcg_reg;
      wcg_s2_reg <= wcg_s1_reg;
    end
  end

  assign rptr_wr = gray2bin(rg_s2_reg);
  assign wcommit_rd = gray2bin(wcg_s2_reg);
  assign q.free_octets = DEPTH_W - (wptr_reg - rptr_wr);
  assign q.stored_octets = wcommit_reg - rptr_wr;
  assign q.avail_octets = wcommit_rd - rptr_reg;
  assign q.head0 = mem_reg[rptr_reg[AW-1:0]];
  assign q.head1 = mem_reg[AW'(rptr_reg[AW-1:0] + 1'b1)];
endmodule // rxcb_cell_queue
`default_nettype wire

// ---- verilog/rxcb_map.svh ----
`ifndef RXCB_MAP_SVH
`define RXCB_MAP_SVH
// Register indices; byte address is four times the index
`define RXCB_CTRL_IDX 16'h0403
`define RXCB_STAT_IDX 16'h0404
`define RXCB_CTRL_RST 8'h83
// Control field positions
`define RXCB_LVL_BIT 7
`define RXCB_WID_HI 3
`define RXCB_WID_LO 2
`define RXCB_SIZE_HI 1
`define RXCB_SIZE_LO 0
// Bus width codes
`define RXCB_WID_OFF 2'h0
`define RXCB_WID_8 2'h1
`define RXCB_WID_16 2'h2
// Cell size codes and octet counts
`define RXCB_SIZE_52 2'h0
`define RXCB_SIZE_53 2'h1
`define RXCB_SIZE_54 2'h2
`define RXCB_SIZE_UNUSED 2'h3
`define RXCB_OCT_52 7'h34
`define RXCB_OCT_53 7'h35
`define RXCB_OCT_54 7'h36
// Status field positions
`define RXCB_STAT_EMPTY 16
`define RXCB_STAT_FULL 17
// Free octets must exceed this before the upstream may push
`define RXCB_READY_MARGIN 11'h002
`endif

// ---- verilog/rxcb_pkg.sv ----
package rxcb_pkg;
  typedef logic [7:0] rxcb_octet_t;
  typedef logic [15:0] rxcb_word_t;
  typedef logic [31:0] rxcb_apb_data_t;
  typedef enum logic {LK_IDLE, LK_CELL} rxcb_link_e;
endpackage

// ---- verilog/rxcb_port.sv ----
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "rxcb_map.svh"
`default_nettype none
module rxcb_port #(
  parameter int AW = 10
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [15:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire rxcb_pkg::rxcb_apb_data_t pwdata, // APB write data
  output rxcb_pkg::rxcb_apb_data_t prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic in_valid, // Upstream octet valid
  input wire rxcb_pkg::rxcb_octet_t in_octet, // Upstream octet
  input wire logic in_end, // Upstream last octet of a cell
  output logic in_ready, // Queue accepts an octet
  input wire logic rx_bus_clock, // Bus clock from the reader
  input wire logic rx_read_enable_n, // Read enable, active low
  output rxcb_pkg::rxcb_word_t rx_cell_data_bus, // Cell data
  output logic [1:0] rx_data_oe_n, // Lane enables, [1] upper, low drives
  output logic rx_start_of_cell, // First word of a cell
  output logic rx_odd_parity_out, // Odd parity of the data
  output logic cell_available_out // Whole cell ready
);
  import rxcb_pkg::*;
  localparam logic [15:0] CTRL_ADDR = `RXCB_CTRL_IDX * 16'h0004;
  localparam logic [15:0] STAT_ADDR = `RXCB_STAT_IDX * 16'h0004;
  localparam logic [7:0] CTRL_RST = `RXCB_CTRL_RST;
  localparam logic [4:0] CFG_RST = {CTRL_RST[`RXCB_LVL_BIT], CTRL_RST[`RXCB_WID_HI:`RXCB_SIZE_LO]};

  rxcb_q_if #(.AW(AW)) q_if ();

  logic [7:0] ctrl_reg;
  logic pready_reg, pslverr_reg, in_ready_reg;
  rxcb_apb_data_t prdata_reg, stat_word;
  logic lrst_s1_reg, lrst_n_reg;
  logic [4:0] cfg_s1_reg, cfg_s2_reg;
  rxcb_link_e state_reg;
  logic [6:0] left_reg;
  rxcb_word_t data_reg;
  logic [1:0] oe_n_reg;
  logic soc_reg, par_reg, clav_reg;
  logic level12, wide, active, start, take, last, whole, clav_next;
  logic [1:0] width, size;
  logic [6:0] cell_oct, left_now, step;
  logic [AW:0] pending;
  rxcb_word_t word;

  function automatic logic [6:0] cell_octets(input logic [1:0] sel);
    unique case (sel)
      `RXCB_SIZE_53: return `RXCB_OCT_53;
      `RXCB_SIZE_54: return `RXCB_OCT_54;
      default: return `RXCB_OCT_52;
    endcase
  endfunction

  rxcb_cell_queue #(.AW(AW)) u_queue (
    .wclk(clk),
    .wrst_n(rstn),
    .rclk(rx_bus_clock),
    .rrst_n(lrst_n_reg),
    .q(q_if)
  );

  // Upstream write side
  assign q_if.push = in_valid && in_ready_reg;
  assign q_if.push_octet = in_octet;
  assign q_if.commit = q_if.push && in_end;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_ready_reg <= 1'b0;
    end else begin
      in_ready_reg <= q_if.free_octets > (AW+1)'(`RXCB_READY_MARGIN);
    end
  end

  // APB slave: one wait state, writes land at the completing edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RST;
    end else if (psel && penable && pready_reg && pwrite && paddr == CTRL_ADDR) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[AW:0] = q_if.stored_octets;
    stat_word[`RXCB_STAT_EMPTY] = q_if.stored_octets == '0;
    stat_word[`RXCB_STAT_FULL] = !in_ready_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && paddr != CTRL_ADDR && paddr != STAT_ADDR;
      if (psel && penable && !pready_reg && !pwrite && paddr == CTRL_ADDR) begin
        prdata_reg <= {24'h000000, ctrl_reg};
      end else if (psel && penable && !pready_reg && !pwrite && paddr == STAT_ADDR) begin
        prdata_reg <= stat_word;
      end else begin
        prdata_reg <= '0;
      end
    end
  end

  // Link reset: asserted at once, released on the bus clock
  always_ff @(posedge rx_bus_clock or negedge rstn) begin
    if (!rstn) begin
      lrst_s1_reg <= 1'b0;
      lrst_n_reg <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_n_reg <= lrst_s1_reg;
    end
  end

  // Quasi-static config; change it only while the bus is idle
  always_ff @(posedge rx_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      cfg_s1_reg <= CFG_RST;
      cfg_s2_reg <= CFG_RST;
    end else begin
      cfg_s1_reg <= {ctrl_reg[`RXCB_LVL_BIT], ctrl_reg[`RXCB_WID_HI:`RXCB_SIZE_LO]};
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  always_comb begin
    level12 = cfg_s2_reg[4];
    width = cfg_s2_reg[3:2];
    size = cfg_s2_reg[1:0];
    wide = width == `RXCB_WID_16;
    // 53 octets cannot split into 16-bit words, so that pairing stays idle
    active = (width == `RXCB_WID_8 && size != `RXCB_SIZE_UNUSED)
             || (wide && (size == `RXCB_SIZE_52 || size == `RXCB_SIZE_54));
    cell_oct = cell_octets(size);
    step = wide ? 7'h02 : 7'h01;
    pending = q_if.avail_octets - ((state_reg == LK_CELL) ? (AW+1)'(left_reg) : '0);
    whole = pending >= (AW+1)'(cell_oct);
    // Cell-level handshake only: a cell starts only when a whole one is queued
    start = active && state_reg == LK_IDLE && clav_reg && !rx_read_enable_n
            && q_if.avail_octets >= (AW+1)'(cell_oct);
    take = start || (state_reg == LK_CELL && !rx_read_enable_n);
    left_now = start ? cell_oct : left_reg;
    last = take && left_now <= step;
    // Levels 1/2 hold the flag through a cell; Level 3 tracks it every clock
    if (level12 && state_reg == LK_CELL && !last) begin
      clav_next = clav_reg;
    end else begin
      clav_next = whole;
    end
    word = wide ? {q_if.head0, q_if.head1} : {q_if.head0, 8'h00};
  end

  assign q_if.pop = take;
  assign q_if.pop_two = wide;

  always_ff @(posedge rx_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      state_reg <= LK_IDLE;
      left_reg <= '0;
    end else if (take) begin
      state_reg <= last ? LK_IDLE : LK_CELL;
      left_reg <= left_now - step;
    end
  end

  always_ff @(posedge rx_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      data_reg <= '0;
      par_reg <= 1'b1;
    end else if (take) begin
      data_reg <= word;
      par_reg <= wide ? ~^word : ~^word[15:8];
    end
  end

  always_ff @(posedge rx_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      soc_reg <= 1'b0;
      oe_n_reg <= 2'h3;
      clav_reg <= 1'b0;
    end else begin
      soc_reg <= start;
      oe_n_reg[1] <= rx_read_enable_n || !active;
      oe_n_reg[0] <= rx_read_enable_n || !active || !wide;
      clav_reg <= active && clav_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign in_ready = in_ready_reg;
  assign rx_cell_data_bus = data_reg;
  assign rx_data_oe_n = oe_n_reg;
  assign rx_start_of_cell = soc_reg;
  assign rx_odd_parity_out = par_reg;
  assign cell_available_out = clav_reg;
endmodule // rxcb_port
`default_nettype wire

// ---- verilog/rxcb_q_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rxcb_q_if #(parameter int AW = 10);
  logic push;
  rxcb_pkg::rxcb_octet_t push_octet;
  logic commit;
  logic [AW:0] free_octets;
  logic [AW:0] stored_octets;
  logic pop;
  logic pop_two;
  rxcb_pkg::rxcb_octet_t head0;
  rxcb_pkg::rxcb_octet_t head1;
  logic [AW:0] avail_octets;
  modport queue (input push, push_octet, commit, pop, pop_two,
                 output free_octets, stored_octets, head0, head1, avail_octets);
  modport user (output push, push_octet, commit, pop, pop_two,
                input free_octets, stored_octets, head0, head1, avail_octets);
endinterface
`default_nettype wire
